// ### src/gbd_top.sv
// apb slave for the high bank pin data register and the bank b toggle register
// assumes qualified pin inputs and pin-mode enables synchronous to pclk
//
// What this block does
// R1: reading high bank data returns each implemented pin's present level, any mode
// R2: writing high bank data drives each pin configured as output high or low
// R3: in other modes the written bit is latched but does not reach the pin
// R4: output latch holds until the next write; only reset also changes it
// R5: reset clears every data bit and every output latch to zero
// R6: read data comes from the qualified pin input, never from the latch
// R7: high bank data at index 38h, bit n is pin 224+n, listed bits implemented
// R8: bank b toggle reads zero, resets zero; bits 0,1,3,5,7,8,9 implemented
// R9: writing one to a toggle bit inverts the latch; zero leaves it
// R10: writes to reserved toggle bits touch no latch or pin
`timescale 1ns/1ps
module gbd_top #(
  parameter int ADDR_W = gbd_pkg::GBD_ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] h_pin_in,
  input wire logic [31:0] h_out_mode,
  output logic [31:0] h_pin_out,
  output logic [31:0] h_pin_oe,
  input wire logic [31:0] b_out_mode,
  output logic [31:0] b_pin_out,
  output logic [31:0] b_pin_oe
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < gbd_pkg::GBD_ADDR_W) begin : g_addr_chk
    $error("gbd_top: ADDR_W too small for the register map");
  end

  localparam logic [ADDR_W-1:0] A_HIGH =
    ADDR_W'(gbd_pkg::gbd_byte_addr(gbd_pkg::GBD_HIGH_DATA_IDX));
  localparam logic [ADDR_W-1:0] A_TOG =
    ADDR_W'(gbd_pkg::gbd_byte_addr(gbd_pkg::GBD_B_TOGGLE_IDX));

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic hit_high;
  logic hit_tog;
  logic wr_high;
  logic wr_tog;
  logic [31:0] h_latch;
  logic [31:0] b_latch;

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign hit_high = (paddr == A_HIGH);
  assign hit_tog = (paddr == A_TOG);
  assign wr_high = access && pwrite && hit_high;
  assign wr_tog = access && pwrite && hit_tog;

  // one wait-free access phase: pready rises for the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // unmapped addresses answer with an error and read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !hit_high && !hit_tog;
    end
  end

  // pins sampled at the setup edge; latch contents never feed the read path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite && hit_high) begin
      prdata <= h_pin_in & gbd_pkg::GBD_HIGH_MASK; // R1 R6 R7
    end else if (setup) begin
      prdata <= gbd_pkg::GBD_TOGGLE_READ; // R8
    end
  end

  // ----------------------------------------------------------------
  // output latches
  // ----------------------------------------------------------------
  // R2 R3 R4 R5: high latch loads only on a completed data write
  gbd_latch #(
    .WIDTH(32),
    .MASK(gbd_pkg::GBD_HIGH_MASK),
    .RST(gbd_pkg::GBD_HIGH_DATA_RST)
  ) u_high_latch (
    .pclk(pclk),
    .presetn(presetn),
    .load_en(wr_high),
    .load_data(pwdata),
    .tog_en(1'b0),
    .tog_data(32'h00000000),
    .q(h_latch)
  );

  // R9 R10: masked toggle keeps reserved positions out of the latch
  gbd_latch #(
    .WIDTH(32),
    .MASK(gbd_pkg::GBD_B_TOGGLE_MASK),
    .RST(gbd_pkg::GBD_B_LATCH_RST)
  ) u_b_latch (
    .pclk(pclk),
    .presetn(presetn),
    .load_en(1'b0),
    .load_data(32'h00000000),
    .tog_en(wr_tog),
    .tog_data(pwdata),
    .q(b_latch)
  );

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // registered drive costs one cycle but keeps the pins glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_pin_out <= 32'h00000000;
      h_pin_oe <= 32'h00000000;
    end else begin
      h_pin_out <= h_latch & h_out_mode; // R2 R3
      h_pin_oe <= h_out_mode & gbd_pkg::GBD_HIGH_MASK; // R3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_pin_out <= 32'h00000000;
      b_pin_oe <= 32'h00000000;
    end else begin
      b_pin_out <= b_latch & b_out_mode; // R9 R10
      b_pin_oe <= b_out_mode & gbd_pkg::GBD_B_TOGGLE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_rd_high;
    s_setup ##0 (!pwrite && hit_high);
  endsequence

  sequence s_rd_tog;
    s_setup ##0 (!pwrite && hit_tog);
  endsequence

  a_read_pin_level: assert property (s_rd_high |=> // R1
      prdata == ($past(h_pin_in) & gbd_pkg::GBD_HIGH_MASK))
    else $error("high data read does not match pin level");

  a_read_not_latch: assert property ((s_rd_high ##0 (h_pin_in == 32'h0)) |=> // R6
      prdata == 32'h0)
    else $error("high data read leaks latch contents");

  a_reserved_read_zero: assert property (s_rd_high |=> // R7
      (prdata & ~gbd_pkg::GBD_HIGH_MASK) == 32'h0)
    else $error("reserved high data bits read nonzero");

  a_write_captures: assert property (wr_high |=> // R2
      h_latch == ($past(pwdata) & gbd_pkg::GBD_HIGH_MASK))
    else $error("high data write not captured in latch");

  a_pin_follows_mode: assert property (wr_high |=> ##1 // R3
      h_pin_out == ($past(pwdata, 2) & gbd_pkg::GBD_HIGH_MASK & $past(h_out_mode)))
    else $error("pin drive ignores written value or mode");

  a_latch_holds: assert property (!wr_high |=> $stable(h_latch)) // R4
    else $error("high latch changed without a write");

  a_reset_clears: assert property (@(posedge pclk) disable iff (1'b0) // R5
      !presetn |-> (h_latch == 32'h0 && b_latch == 32'h0 && prdata == 32'h0))
    else $error("reset did not clear latches and data");

  a_toggle_reads_zero: assert property (s_rd_tog |=> prdata == 32'h0) // R8
    else $error("toggle register read nonzero");

  a_toggle_flips: assert property (wr_tog |=> // R9
      b_latch == ($past(b_latch) ^ ($past(pwdata) & gbd_pkg::GBD_B_TOGGLE_MASK)))
    else $error("toggle write did not invert latch");

  a_toggle_reserved: assert property (!wr_tog |=> $stable(b_latch)) // R10
    else $error("bank b latch changed without a toggle");

  a_b_reserved_zero: assert property ((b_latch & ~gbd_pkg::GBD_B_TOGGLE_MASK) == 32'h0) // R10
    else $error("reserved toggle position holds state");

  a_ready_one_cycle: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single access cycle");

  a_high_oe_mode: assert property (1'b1 |=> // R3
      h_pin_oe == ($past(h_out_mode) & gbd_pkg::GBD_HIGH_MASK))
    else $error("high pin enable does not follow mode");

  a_b_oe_mask: assert property (1'b1 |=> // R8
      b_pin_oe == ($past(b_out_mode) & gbd_pkg::GBD_B_TOGGLE_MASK))
    else $error("bank b pin enable does not follow mode");

  a_unmapped_error: assert property ((s_setup ##0 !(hit_high || hit_tog)) |=>
      pready && pslverr)
    else $error("unmapped access did not answer with an error");

  a_reset_pins: assert property (@(posedge pclk) disable iff (1'b0) // R5
      !presetn |-> (h_pin_out == 32'h0 && b_pin_out == 32'h0 && h_pin_oe == 32'h0))
    else $error("reset did not clear pin drive");

endmodule

// ### src/gbd_pkg.sv
// constants of the pin data and toggle block: register map, field masks, reset values
// assumes a 32-bit apb slave with one aligned word per register
package gbd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  // printed offsets are word indices; byte address is four times that
  localparam logic [7:0] GBD_HIGH_DATA_IDX = 8'h38;
  localparam logic [7:0] GBD_B_TOGGLE_IDX = 8'h0E;
  localparam int GBD_ADDR_W = 8;
  localparam int GBD_DATA_W = 32;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  // high bank: bit n is pin 224 + n
  localparam int GBD_HIGH_FIRST_PIN = 224;
  localparam logic [31:0] GBD_HIGH_MASK = 32'h0036E3DF;
  // bank b toggle: bit n is pin 32 + n
  localparam int GBD_B_FIRST_PIN = 32;
  localparam logic [31:0] GBD_B_TOGGLE_MASK = 32'h000003AB;
  localparam logic [31:0] GBD_HIGH_DATA_RST = 32'h00000000;
  localparam logic [31:0] GBD_B_LATCH_RST = 32'h00000000;
  localparam logic [31:0] GBD_TOGGLE_READ = 32'h00000000;

  function automatic logic [GBD_ADDR_W-1:0] gbd_byte_addr(input logic [7:0] idx);
    gbd_byte_addr = GBD_ADDR_W'({idx, 2'b00});
  endfunction

endpackage

// ### src/gbd_latch.sv
// output latch bank: load and toggle with a mask of implemented bits
// assumes one-cycle write and toggle strobes from the register slave
`timescale 1ns/1ps
module gbd_latch #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] MASK = '1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load_en,
  input wire logic [WIDTH-1:0] load_data,
  input wire logic tog_en,
  input wire logic [WIDTH-1:0] tog_data,
  output logic [WIDTH-1:0] q
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (WIDTH < 1) begin : g_width_chk
    $error("gbd_latch: WIDTH must be at least 1");
  end

  // ----------------------------------------------------------------
  // latch
  // ----------------------------------------------------------------
  // unimplemented bits never hold state, so reserved writes vanish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST & MASK;
    end else if (load_en) begin
      q <= load_data & MASK;
    end else if (tog_en) begin
      q <= q ^ (tog_data & MASK);
    end
  end

endmodule

// ### sim/gbd_pin_model.sv
// far-side pin model: external drivers and the input qualifier
// assumes pin outputs and enables from gbd_top, all on pclk
`timescale 1ns/1ps
module gbd_pin_model (
  input wire logic pclk,
  input wire logic [31:0] ext_level,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  output logic [31:0] pin_in
);
  // ----------------------------------------------------------------
  // pin level
  // ----------------------------------------------------------------
  // one flop stands in for qualification, so reads lag the pin a cycle
  always_ff @(posedge pclk) begin
    pin_in <= (pin_oe & pin_out) | (~pin_oe & ext_level);
  end
endmodule

// ### sim/tb_top.sv
// bench for gbd_top: apb tests of pin data and toggle registers
// assumes the pin model stands on the far side of the pins
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [31:0] HM = gbd_pkg::GBD_HIGH_MASK;
  localparam logic [31:0] BM = gbd_pkg::GBD_B_TOGGLE_MASK;
  localparam logic [7:0] HA = 8'(gbd_pkg::GBD_HIGH_DATA_IDX << 2);
  localparam logic [7:0] TA = 8'(gbd_pkg::GBD_B_TOGGLE_IDX << 2);
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] h_out_mode = 32'h0;
  logic [31:0] b_out_mode = 32'h0;
  logic [31:0] ext = 32'h0;
  logic [31:0] prdata, h_pin_in, h_pin_out, h_pin_oe, b_pin_out, b_pin_oe, rd;
  logic pready, pslverr, err;
  int mismatches = 0;
  int checks = 0;

  always #4 pclk = ~pclk;

  gbd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .h_pin_in(h_pin_in), .h_out_mode(h_out_mode),
    .h_pin_out(h_pin_out), .h_pin_oe(h_pin_oe), .b_out_mode(b_out_mode),
    .b_pin_out(b_pin_out), .b_pin_oe(b_pin_oe));
  gbd_pin_model pm (.pclk(pclk), .ext_level(ext), .pin_out(h_pin_out), .pin_oe(h_pin_oe),
    .pin_in(h_pin_in));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // idle edge first, so back-to-back calls never drive psel twice at once
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) mismatches++;
  endtask

  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(HA, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(h_pin_out | b_pin_out, 32'h0);
    apb(TA, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("reset values done");
  endtask

  task automatic t_data();
    h_out_mode <= 32'hFFFFFFFF;
    ext <= 32'hFFFFFFFF;
    apb(HA, 1'b1, 32'h5A5AC3C3);
    settle();
    chk(h_pin_out, 32'h5A5AC3C3 & HM);
    chk(h_pin_oe, HM);
    apb(HA, 1'b0, 32'h0);
    chk(rd, 32'h5A5AC3C3 & HM);
    // mode off: pin shows the outside level while the latch keeps the write
    h_out_mode <= 32'h0;
    ext <= 32'h12345678;
    apb(HA, 1'b1, 32'hA5A53C3C);
    settle();
    chk(h_pin_out, 32'h0);
    apb(HA, 1'b0, 32'h0);
    chk(rd, 32'h12345678 & HM);
    // pins low while the latch holds a nonzero word
    ext <= 32'h0;
    apb(HA, 1'b0, 32'h0);
    chk(rd, 32'h0);
    h_out_mode <= 32'hFFFFFFFF;
    settle();
    chk(h_pin_out, 32'hA5A53C3C & HM);
    $display("data register done");
  endtask

  task automatic t_toggle();
    logic [31:0] e;
    b_out_mode <= 32'hFFFFFFFF;
    e = BM;
    apb(TA, 1'b1, 32'hFFFFFFFF);
    settle();
    chk(b_pin_out, e);
    chk(b_pin_oe, BM);
    apb(TA, 1'b1, 32'h0);
    apb(TA, 1'b1, ~BM);
    settle();
    chk(b_pin_out, e);
    apb(TA, 1'b1, 32'h00000209);
    e = e ^ 32'h00000209;
    settle();
    chk(b_pin_out, e);
    apb(TA, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(8'hF0, 1'b1, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h1);
    settle();
    chk(h_pin_out, 32'hA5A53C3C & HM);
    $display("toggle and unmapped done");
  endtask

  task automatic t_midreset();
    presetn <= 1'b0;
    @(posedge pclk);
    chk(h_pin_out | b_pin_out, 32'h0);
    presetn <= 1'b1;
    settle();
    chk(h_pin_out | b_pin_out, 32'h0);
    apb(HA, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("mid-run reset done");
  endtask

  initial begin
    // a real falling edge, so state clears before the first clock
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_data();
    t_toggle();
    t_midreset();
    conclude();
  end

  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule
